// [ddr_burst_pkg.sv]
// Package of constants and types shared by both ends of the burst SRAM link.
package ddr_burst_pkg;

  // ***************************************************************
  // Geometry
  // ***************************************************************
  localparam int WORD_W  = 18;
  localparam int LANES   = 2;
  localparam int LANE_W  = 9;
  localparam int ADDR_W  = 8;
  localparam int BURST   = 2;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int LINK_PERIOD_NS = 125;
  localparam int LINK_DIV       = LINK_PERIOD_NS / CLK_PERIOD_NS / 2;
  localparam int ZQ_PERIOD      = 1024;
  localparam int LAT_PLL        = 2;
  localparam int LAT_LEGACY     = 1;
  localparam int TURN_IDLES     = 2;
  localparam int FIFO_DEPTH     = 16;

  // ***************************************************************
  // Controller states
  // ***************************************************************
  typedef enum logic [1:0] {
    CTL_IDLE = 2'b00,
    CTL_WR0  = 2'b01,
    CTL_WR1  = 2'b11,
    CTL_TURN = 2'b10
  } ctl_state_type;

endpackage : ddr_burst_pkg

// [ddr_burst_if.sv]
// Interface joining the memory device and the memory controller.
`timescale 1ns/1ps
interface ddr_burst_if;
  logic                               kp;
  logic                               kn;
  logic                               transfer_select_n;
  logic                               rw_sel;
  logic [ddr_burst_pkg::ADDR_W-1:0]   addr;
  logic [ddr_burst_pkg::LANES-1:0]    byte_lane_select_n;
  logic [ddr_burst_pkg::WORD_W-1:0]   dq_ctl;
  logic                               dq_ctl_oe;
  logic [ddr_burst_pkg::WORD_W-1:0]   dq_mem;
  logic                               dq_mem_oe;
  logic                               echo_out_pos;
  logic                               echo_out_neg;
  logic                               output_valid_flag;
  logic                               pll_bypass_n;

  modport mem (
    input  kp, kn, transfer_select_n, rw_sel, addr, byte_lane_select_n,
    input  dq_ctl, dq_ctl_oe, pll_bypass_n,
    output dq_mem, dq_mem_oe, echo_out_pos, echo_out_neg, output_valid_flag
  );
  modport ctl (
    output kp, kn, transfer_select_n, rw_sel, addr, byte_lane_select_n,
    output dq_ctl, dq_ctl_oe, pll_bypass_n,
    input  dq_mem, dq_mem_oe, echo_out_pos, echo_out_neg, output_valid_flag
  );
endinterface : ddr_burst_if

// [ddr_burst_mem.sv]
// Device end: burst SRAM core sequenced on sampled link clock edges.
`timescale 1ns/1ps
module ddr_burst_mem #(
  parameter int DEPTH = 1 << ddr_burst_pkg::ADDR_W
) (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  // Link.
  ddr_burst_if.mem  bus,
  // Status.
  output logic      o_zq_update
);
  localparam int W = ddr_burst_pkg::WORD_W;
  localparam int A = ddr_burst_pkg::ADDR_W;
  localparam int L = ddr_burst_pkg::LANE_W;

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [1:0]   kp_s;
    logic [1:0]   kn_s;
    logic         kp_d;
    logic         kn_d;
    logic [1:0]   bp_s;
    logic [2:0]   rd_pipe;
    logic [A-1:0] rd_a0;
    logic [A-1:0] rd_a1;
    logic [1:0]   wr_pipe;
    logic [A-1:0] wr_a;
    logic         hold_v;
    logic [A-1:0] hold_a;
    logic [W-1:0] hold_d0;
    logic [W-1:0] hold_d1;
    logic [1:0]   hold_m0;
    logic [1:0]   hold_m1;
    logic         out_phase;
    logic [A-1:0] out_a;
    logic [W-1:0] dq;
    logic         oe;
    logic         vld;
    logic [9:0]   zq_cnt;
    logic         zq;
  } mem_state_type;

  mem_state_type st;
  mem_state_type next_st;
  logic [W-1:0]  array [DEPTH];
  logic          commit;
  logic [A-1:0]  commit_a;
  logic [W-1:0]  commit_d0;
  logic [W-1:0]  commit_d1;
  logic [1:0]    commit_m0;
  logic [1:0]    commit_m1;

  function automatic logic [W-1:0] merge(input logic [W-1:0] old_w,
                                         input logic [W-1:0] new_w,
                                         input logic [1:0]   sel_n);
    logic [W-1:0] r;
    r = old_w;
    for (int i = 0; i < ddr_burst_pkg::LANES; i++)
      if (!sel_n[i])
        r[i*L +: L] = new_w[i*L +: L];
    return r;
  endfunction : merge

  function automatic logic [W-1:0] fetch(input logic [A-1:0] a,
                                         input mem_state_type s);
    logic [W-1:0] r;
    r = array[a];
    if (s.hold_v && s.hold_a == a)
      r = merge(r, s.hold_d0, s.hold_m0);
    if (s.hold_v && s.hold_a + A'(1) == a)
      r = merge(r, s.hold_d1, s.hold_m1);
    return r;
  endfunction : fetch

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    logic kp_rise;
    logic kn_rise;
    logic rd_now;
    logic wr_now;
    logic [A-1:0] ra;
    kp_rise   = 1'b0;
    kn_rise   = 1'b0;
    rd_now    = 1'b0;
    wr_now    = 1'b0;
    ra        = '0;
    next_st   = st;
    commit    = 1'b0;
    commit_a  = st.hold_a;
    commit_d0 = st.hold_d0;
    commit_d1 = st.hold_d1;
    commit_m0 = st.hold_m0;
    commit_m1 = st.hold_m1;
    next_st.kp_s = {st.kp_s[0], bus.kp};
    next_st.kn_s = {st.kn_s[0], bus.kn};
    next_st.bp_s = {st.bp_s[0], bus.pll_bypass_n};
    next_st.kp_d = st.kp_s[1];
    next_st.kn_d = st.kn_s[1];
    kp_rise = st.kp_s[1] && !st.kp_d;
    kn_rise = st.kn_s[1] && !st.kn_d;
    next_st.zq = 1'b0;
    next_st.zq_cnt = st.zq_cnt + 10'd1;
    if (st.zq_cnt == 10'(ddr_burst_pkg::ZQ_PERIOD - 1))
      next_st.zq = 1'b1;
    if (kp_rise)
    begin
      // Controls are sampled only here.
      rd_now = !bus.transfer_select_n && bus.rw_sel;
      wr_now = !bus.transfer_select_n && !bus.rw_sel;
      next_st.rd_pipe = {st.rd_pipe[1:0], rd_now};
      next_st.rd_a1 = st.rd_a0;
      next_st.rd_a0 = bus.addr;
      next_st.wr_pipe = {st.wr_pipe[0], wr_now};
      if (wr_now)
        next_st.wr_a = bus.addr;
      if (st.wr_pipe[0])
      begin
        next_st.hold_d0 = bus.dq_ctl;
        next_st.hold_m0 = bus.byte_lane_select_n;
        next_st.hold_a  = st.wr_a;
      end
      // The posted write drains before its holding registers are reused.
      if (st.wr_pipe[0] && st.hold_v)
        commit = 1'b1;
      // Selected latency counts positive rises since the load.
      if (st.bp_s[1] ? st.rd_pipe[1] : st.rd_pipe[0])
      begin
        ra = st.bp_s[1] ? st.rd_a1 : st.rd_a0;
        next_st.dq = fetch(ra, st);
        next_st.out_a = ra + A'(1);
        next_st.oe = 1'b1;
        next_st.out_phase = 1'b1;
      end
      else
        next_st.oe = 1'b0;
    end
    if (kn_rise)
    begin
      if (st.wr_pipe[1])
      begin
        next_st.hold_d1 = bus.dq_ctl;
        next_st.hold_m1 = bus.byte_lane_select_n;
        next_st.hold_v  = 1'b1;
      end
      if (st.out_phase)
      begin
        next_st.dq = fetch(st.out_a, st);
        next_st.out_phase = 1'b0;
      end
      // The flag rises half a cycle ahead of the first read word.
      next_st.vld = st.bp_s[1] ? st.rd_pipe[1] : st.rd_pipe[0];
    end
    if (commit && !(kn_rise && st.wr_pipe[1]))
      next_st.hold_v = 1'b0;
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st <= '0;
    else if (i_ce)
      st <= next_st;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_ce && commit)
    begin
      array[commit_a] <= merge(array[commit_a], commit_d0, commit_m0);
      array[commit_a + A'(1)] <=
        merge(array[commit_a + A'(1)], commit_d1, commit_m1);
    end
  end

  assign bus.dq_mem            = st.dq;
  assign bus.dq_mem_oe         = st.oe;
  assign bus.echo_out_pos      = st.kp_d;
  assign bus.echo_out_neg      = st.kn_d;
  assign bus.output_valid_flag = st.vld;
  assign o_zq_update           = st.zq;

endmodule : ddr_burst_mem

// [ddr_burst_fifo.sv]
// Parameterised valid/ready FIFO for controller read and write requests.
`timescale 1ns/1ps
module ddr_burst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = ddr_burst_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_ce,
  // Fill side.
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // Drain side.
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wp;
  logic [PW:0]      rp;
  logic             push;
  logic             pop;

  assign o_ready = (wp - rp) != (PW+1)'(DEPTH);
  assign o_valid = wp != rp;
  assign o_data  = mem[rp[PW-1:0]];
  assign push    = i_ce && i_valid && o_ready;
  assign pop     = i_ce && o_valid && i_ready;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + (PW+1)'(1);
      if (pop)
        rp <= rp + (PW+1)'(1);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wp[PW-1:0]] <= i_data;
  end
endmodule : ddr_burst_fifo

// [ddr_burst_ctl.sv]
// Controller end: makes link clocks, issues bursts, collects read data.
`timescale 1ns/1ps
module ddr_burst_ctl (
  // Clock and reset.
  input  wire logic                                i_clk,
  input  wire logic                                i_rstn,
  input  wire logic                                i_ce,
  // Mode.
  input  wire logic                                i_pll_on,
  // Request.
  input  wire logic                                i_req_valid,
  output logic                                     o_req_ready,
  input  wire logic                                i_req_write,
  input  wire logic [ddr_burst_pkg::ADDR_W-1:0]    i_req_addr,
  input  wire logic [2*ddr_burst_pkg::WORD_W-1:0]  i_req_data,
  input  wire logic [2*ddr_burst_pkg::LANES-1:0]   i_req_sel_n,
  // Read answer.
  output logic                                     o_rd_valid,
  output logic [ddr_burst_pkg::WORD_W-1:0]         o_rd_data,
  // Link.
  ddr_burst_if.ctl                                 bus
);
  localparam int W  = ddr_burst_pkg::WORD_W;
  localparam int A  = ddr_burst_pkg::ADDR_W;
  localparam int N  = ddr_burst_pkg::LANES;
  localparam int FW = 1 + A + 2*W + 2*N;

  typedef struct packed {
    logic [3:0]                  div;
    logic                        kp;
    ddr_burst_pkg::ctl_state_type fsm;
    logic [1:0]                  idle;
    logic                        last_rd;
    logic                        ld_n;
    logic                        rw;
    logic [A-1:0]                a;
    logic [2*W-1:0]              wd;
    logic [2*N-1:0]              wm;
    logic                        w1_pend;
    logic [W-1:0]                w1_d;
    logic [N-1:0]                w1_m;
    logic [W-1:0]                dq;
    logic [N-1:0]                sel_n;
    logic                        oe;
    logic [1:0]                  vs;
    logic [1:0]                  es;
    logic [1:0]                  ns;
    logic                        e_d;
    logic                        n_d;
    logic                        rv;
    logic [W-1:0]                rd;
  } ctl_state_type;

  ctl_state_type   st;
  ctl_state_type   next_st;
  logic            f_valid;
  logic            f_ready;
  logic [FW-1:0]   f_data;
  logic            kp_edge;

  ddr_burst_fifo #(.WIDTH(FW), .DEPTH(ddr_burst_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_ce    (i_ce),
    .i_valid (i_req_valid),
    .o_ready (o_req_ready),
    .i_data  ({i_req_write, i_req_addr, i_req_data, i_req_sel_n}),
    .o_valid (f_valid),
    .i_ready (f_ready),
    .o_data  (f_data)
  );

  // ***************************************************************
  // Sequencing
  // ***************************************************************
  assign kp_edge = st.div == 4'(ddr_burst_pkg::LINK_DIV - 1) && !st.kp;

  always_comb
  begin
    logic wr;
    wr      = f_data[FW-1];
    next_st = st;
    f_ready = 1'b0;
    next_st.div = st.div + 4'd1;
    if (st.div == 4'(ddr_burst_pkg::LINK_DIV - 1))
    begin
      next_st.div = '0;
      next_st.kp  = !st.kp;
    end
    if (kp_edge)
    begin
      next_st.ld_n = 1'b1;
      next_st.oe   = st.fsm == ddr_burst_pkg::CTL_WR0;
      if (st.fsm == ddr_burst_pkg::CTL_WR0)
      begin
        // Second word is kept apart, as a pipelined load reuses wd.
        next_st.dq      = st.wd[2*W-1:W];
        next_st.sel_n   = st.wm[2*N-1:N];
        next_st.w1_pend = 1'b1;
        next_st.w1_d    = st.wd[W-1:0];
        next_st.w1_m    = st.wm[N-1:0];
      end
      next_st.fsm = (st.fsm == ddr_burst_pkg::CTL_WR0) ?
                    ddr_burst_pkg::CTL_WR1 : ddr_burst_pkg::CTL_IDLE;
      if (st.idle != 2'd0)
        next_st.idle = st.idle - 2'd1;
      if (f_valid && !(wr && st.last_rd && st.idle != 2'd0))
      begin
        f_ready      = 1'b1;
        next_st.ld_n = 1'b0;
        next_st.rw   = !wr;
        next_st.a    = f_data[FW-2 -: A];
        next_st.wd   = f_data[2*N +: 2*W];
        next_st.wm   = f_data[2*N-1:0];
        next_st.last_rd = !wr;
        if (wr)
          next_st.fsm = ddr_burst_pkg::CTL_WR0;
        else
          next_st.idle = 2'(ddr_burst_pkg::TURN_IDLES + 1);
      end
    end
    if (st.div == 4'(ddr_burst_pkg::LINK_DIV - 1) && st.kp && st.w1_pend)
    begin
      next_st.dq      = st.w1_d;
      next_st.sel_n   = st.w1_m;
      next_st.w1_pend = 1'b0;
    end
    next_st.es  = {st.es[0], bus.echo_out_pos};
    next_st.ns  = {st.ns[0], bus.echo_out_neg};
    next_st.vs  = {st.vs[0], bus.output_valid_flag};
    next_st.e_d = st.es[1];
    next_st.n_d = st.ns[1];
    next_st.rv  = 1'b0;
    if (((st.es[1] && !st.e_d) || (st.ns[1] && !st.n_d)) && bus.dq_mem_oe)
    begin
      next_st.rv = 1'b1;
      next_st.rd = bus.dq_mem;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st      <= '0;
      st.ld_n <= 1'b1;
    end
    else if (i_ce)
      st <= next_st;
  end

  assign bus.kp                 = st.kp;
  assign bus.kn                 = !st.kp;
  assign bus.transfer_select_n  = st.ld_n;
  assign bus.rw_sel             = st.rw;
  assign bus.addr               = st.a;
  assign bus.byte_lane_select_n = st.sel_n;
  assign bus.dq_ctl             = st.dq;
  assign bus.dq_ctl_oe          = st.oe;
  assign bus.pll_bypass_n       = i_pll_on;
  assign o_rd_valid             = st.rv;
  assign o_rd_data              = st.rd;

endmodule : ddr_burst_ctl

// [ddr_burst_chk.sv]
// Checker of the link between the burst memory and its controller.
`timescale 1ns/1ps
module ddr_burst_chk (
  // Clock and reset.
  input wire logic                             i_clk,
  input wire logic                             i_rstn,
  // Link.
  input wire logic                             kp,
  input wire logic                             kn,
  input wire logic                             transfer_select_n,
  input wire logic                             rw_sel,
  input wire logic [ddr_burst_pkg::ADDR_W-1:0] addr,
  input wire logic [ddr_burst_pkg::LANES-1:0]  byte_lane_select_n,
  input wire logic [ddr_burst_pkg::WORD_W-1:0] dq_ctl,
  input wire logic                             dq_ctl_oe,
  input wire logic [ddr_burst_pkg::WORD_W-1:0] dq_mem,
  input wire logic                             dq_mem_oe,
  input wire logic                             echo_out_pos,
  input wire logic                             echo_out_neg,
  input wire logic                             output_valid_flag,
  input wire logic                             pll_bypass_n
);
  // ***************************************************************
  // Helper logic
  // ***************************************************************
  logic       kp_q;
  logic       kp_rise;
  logic       rd_load;
  logic       wr_load;
  logic [7:0] since_rd;
  logic [7:0] since_wr;

  assign kp_rise = kp & ~kp_q;
  assign rd_load = kp_rise & ~transfer_select_n & rw_sel;
  assign wr_load = kp_rise & ~transfer_select_n & ~rw_sel;

  // Counters saturate so that a long idle spell never wraps round.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      kp_q     <= 1'b0;
      since_rd <= 8'hFF;
      since_wr <= 8'hFF;
    end
    else
    begin
      kp_q     <= kp;
      since_rd <= rd_load ? 8'h00 : since_rd + {7'h00, since_rd != 8'hFF};
      since_wr <= wr_load ? 8'h00 : since_wr + {7'h00, since_wr != 8'hFF};
    end
  end

  // ***************************************************************
  // Properties
  // ***************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence rd_pll_s;
    rd_load && pll_bypass_n;
  endsequence
  sequence rd_legacy_s;
    rd_load && !pll_bypass_n;
  endsequence

  no_contention_a: assert property (!(dq_mem_oe && dq_ctl_oe))
    else $error("both ends drive the data bus");
  turn_gap_a: assert property (wr_load |-> since_rd >= 8'd35)
    else $error("write loaded too soon after a read");
  pll_latency_a: assert property (rd_pll_s |-> ##[20:40] dq_mem_oe)
    else $error("read data late in two-cycle mode");
  legacy_latency_a: assert property (rd_legacy_s |-> ##[8:24] dq_mem_oe)
    else $error("read data late in one-cycle mode");
  idle_float_a: assert property (since_rd > 8'd60 |-> !dq_mem_oe)
    else $error("device drives data with no read pending");
  valid_lead_a: assert property ($rose(output_valid_flag) |-> ##[3:8] dq_mem_oe)
    else $error("valid flag not followed by data");
  read_burst_a: assert property ($rose(dq_mem_oe) |-> dq_mem_oe [*8])
    else $error("read burst cut short");
  write_data_a: assert property (wr_load |-> ##[1:30] dq_ctl_oe)
    else $error("write data not driven after load");
  write_drive_a: assert property (dq_ctl_oe |-> since_wr <= 8'd36)
    else $error("controller drives data without a write");
  echo_pos_a: assert property ($rose(kp) |-> ##[1:6] $rose(echo_out_pos))
    else $error("positive echo clock missing");
  echo_neg_a: assert property ($rose(kn) |-> ##[1:6] $rose(echo_out_neg))
    else $error("negative echo clock missing");
endmodule : ddr_burst_chk

// [tb_ddr_burst2_sram_interface.sv]
// Testbench joining controller and memory ends across the link.
`timescale 1ns/1ps
module tb_ddr_burst2_sram_interface;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        pll_on = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [7:0]  req_addr = 8'h00;
  logic [35:0] req_data = 36'h0_0000_0000;
  logic [3:0]  req_sel_n = 4'h0;
  logic        req_ready;
  logic        rd_valid;
  logic [17:0] rd_data;
  logic        zq_update;
  logic        full_seen = 1'b0;
  logic [17:0] mdl [256];
  logic [17:0] rdq [$];
  int          fails = 0;
  int          tests_run = 0;

  always #(ddr_burst_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  ddr_burst_if link ();

  ddr_burst_mem i_ddr_burst_mem (.i_clk(clk), .i_rstn(rstn), .i_ce(1'b1),
    .bus(link.mem), .o_zq_update(zq_update));

  ddr_burst_ctl i_ddr_burst_ctl (.i_clk(clk), .i_rstn(rstn), .i_ce(1'b1),
    .i_pll_on(pll_on), .i_req_valid(req_valid), .o_req_ready(req_ready),
    .i_req_write(req_write), .i_req_addr(req_addr), .i_req_data(req_data),
    .i_req_sel_n(req_sel_n), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .bus(link.ctl));

  ddr_burst_chk i_ddr_burst_chk (.i_clk(clk), .i_rstn(rstn), .kp(link.kp),
    .kn(link.kn), .transfer_select_n(link.transfer_select_n),
    .rw_sel(link.rw_sel), .addr(link.addr),
    .byte_lane_select_n(link.byte_lane_select_n), .dq_ctl(link.dq_ctl),
    .dq_ctl_oe(link.dq_ctl_oe), .dq_mem(link.dq_mem),
    .dq_mem_oe(link.dq_mem_oe), .echo_out_pos(link.echo_out_pos),
    .echo_out_neg(link.echo_out_neg),
    .output_valid_flag(link.output_valid_flag),
    .pll_bypass_n(link.pll_bypass_n));

  // Collects read words and notes any refused request.
  always @(posedge clk)
  begin
    if (rd_valid === 1'b1)
      rdq.push_back(rd_data);
    if (req_valid === 1'b1 && req_ready === 1'b0)
      full_seen <= 1'b1;
  end

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Hands one request over and mirrors writes into the lane model.
  task automatic send(input logic wr, input logic [7:0] a,
                      input logic [35:0] d, input logic [3:0] s);
    int         n;
    logic [7:0] idx;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr  <= a;
    req_data  <= d;
    req_sel_n <= s;
    @(posedge clk);
    while (req_ready !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    req_valid <= 1'b0;
    if (n >= 2000)
      check(36'h0_0000_0000, 36'h0_0000_0001);
    for (int w = 0; w < 2; w++)
      for (int l = 0; l < 2; l++)
        if (wr && !s[2 * (1 - w) + l])
        begin
          idx = a + 8'(w);
          mdl[idx][9 * l +: 9] = d[18 * (1 - w) + 9 * l +: 9];
        end
  endtask : send

  // Reads one burst and compares both words with the model.
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    rdq.delete();
    send(1'b0, a, 36'h0_0000_0000, 4'h0);
    while (rdq.size() < 2 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    if (rdq.size() < 2)
      check(36'h0_0000_0000, 36'h0_0000_0002);
    else
    begin
      check(36'(rdq[0]), 36'(mdl[a]));
      check(36'(rdq[1]), 36'(mdl[8'(a + 8'h01)]));
    end
  endtask : rd

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic s_basic();
    send(1'b1, 8'h10, 36'h1_2345_6789, 4'h0);
    send(1'b1, 8'hFF, 36'h2_468A_CE13, 4'h0);
    rd(8'h10);
    rd(8'hFF);
  endtask : s_basic

  task automatic s_lanes();
    for (int s = 0; s < 16; s++)
    begin
      send(1'b1, 8'h40, 36'h0_0000_0000, 4'h0);
      send(1'b1, 8'h40, 36'hA_BCDE_F123, 4'(s));
      rd(8'h40);
    end
  endtask : s_lanes

  task automatic s_forward();
    send(1'b1, 8'h80, 36'h5_5AA5_A55A, 4'h0);
    rd(8'h80);
    send(1'b1, 8'h90, 36'h3_C3C3_3C3C, 4'h0);
    rd(8'h80);
    rd(8'h90);
  endtask : s_forward

  task automatic s_fill();
    for (int i = 0; i < 20; i++)
      send(1'b1, 8'(8'h20 + 2 * i), {4'h0, 32'(i * 32'h0101_0101)}, 4'h0);
    check(36'(full_seen), 36'h0_0000_0001);
    for (int i = 0; i < 20; i++)
      rd(8'(8'h20 + 2 * i));
  endtask : s_fill

  task automatic s_legacy();
    @(posedge clk);
    pll_on <= 1'b0;
    repeat (40) @(posedge clk);
    send(1'b1, 8'h05, 36'h7_0F0F_F0F0, 4'h0);
    rd(8'h05);
    @(posedge clk);
    pll_on <= 1'b1;
    repeat (40) @(posedge clk);
  endtask : s_legacy

  task automatic s_zq();
    int n;
    n = 0;
    while (zq_update !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    @(posedge clk);
    while (zq_update !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    check(36'(n + 1), 36'(ddr_burst_pkg::ZQ_PERIOD));
  endtask : s_zq

  // ***************************************************************
  // Main sequence and watchdog
  // ***************************************************************
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    s_basic();
    s_lanes();
    s_forward();
    s_fill();
    s_legacy();
    s_zq();
    tally_and_finish();
  end

  initial
  begin
    #(400_000);
    fails++;
    $display("Error at %0t: run did not complete", $time);
    tally_and_finish();
  end
endmodule : tb_ddr_burst2_sram_interface
